/* logic/bps_top.sv */
// backup power supervisor: mode switching, stamps, status, shared pin, axi4-lite regs
// Overview of operation
// - enter backup below battery-hys and trip
// - leave backup above battery+hys or trip+hys
// - serial bus disabled while in backup
// - other functions keep running in backup, except battery monitor (idle) and temp conversion (only if enabled)
// - stamp time on each switchover direction
// - keep first to-battery, latest to-main stamp
// - to-battery stamp held until clear bit
// - battery temp enable gates backup conversion
// - flag power-up after total power loss
// - brownout flag from one of six levels
// - brownout alone leaves bus enabled
// - battery flags below 85 and 75 percent
// - battery monitor idle in backup; measure on enable
// - alarm match on chosen fields, flag and irq
// - repeat alarm fires on every match
// - shared pin: interrupt or frequency, open drain
// - interrupt role pulls pin low
// - frequency role outputs divided crystal clock
// - serial data driven open drain only
// - serial clock input gated in backup
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "bps_consts.svh"
module bps_top #(
   parameter int PULSE_CYC = (`BPS_CLK_HZ / 1000) * `BPS_PULSE_MS
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [3:0]        s_axi_awaddr_lo,
   input  wire logic [4:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire bps_pkg::bps_word_t s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [4:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output bps_pkg::bps_word_t     s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [12:0]       cmp_in,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   input  wire logic              sda_drive_low,
   input  wire logic [15:0]       freq_taps,
   output logic                   sda_out,
   output logic                   sda_oe,
   output logic                   scl_gated,
   output logic                   sda_gated,
   output logic                   interrupt_or_freq_pin_out,
   output logic                   interrupt_or_freq_pin_oe,
   output logic                   temp_run,
   output logic                   bat_meas_run
);
   import bps_pkg::*;

   bps_sync_if sif ();
   bps_mode_e  mode_r;
   bps_word_t  time_r;
   bps_word_t  alarm_r;
   bps_word_t  amask_r;
   bps_word_t  stamp_b_r;
   bps_word_t  stamp_m_r;
   logic       stamp_b_v_r;
   logic [10:0] ctrl_r;
   logic [5:0] brown_sel_r;
   logic       tpl_r;
   logic       tpl_seen_r;
   logic       brown_r;
   logic       lb85_r;
   logic       lb75_r;
   logic       alarm_r_f;
   logic       match_d_r;
   logic [31:0] pulse_cnt_r;
   logic [7:0] meas_cnt_r;
   logic [1:0] scl_s_r;
   logic [1:0] sda_s_r;
   logic       aw_got_r;
   logic       w_got_r;
   logic [4:0] aw_addr_r;
   bps_word_t  w_data_r;
   logic [3:0] w_strb_r;
   logic       in_backup;
   logic       match;
   logic       wr_go;
   logic       freq_mode;
   logic       clr_ts;
   logic       clr_alarm;
   logic       clr_tpl;

   bps_sync #(
      .W (13)
   ) u_sync (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .din       (cmp_in),
      .brown_sel (brown_sel_r),
      .so        (sif)
   );

   function automatic logic [7:0] byte_addr(input logic [4:0] a);
      byte_addr = {1'b0, a, 2'b00};
   endfunction

   assign in_backup = (mode_r == BPS_BACKUP);
   assign freq_mode = (ctrl_r[`BPS_CTRL_FSEL_LSB +: `BPS_CTRL_FSEL_W] != 4'h0);
   assign wr_go     = aw_got_r && w_got_r && !s_axi_bvalid;
   assign clr_ts    = wr_go && byte_addr(aw_addr_r) == `BPS_ADDR_CTRL && w_strb_r[1]
                      && w_data_r[`BPS_CTRL_STAMP_CLEAR_CONTROL];
   assign clr_alarm = wr_go && byte_addr(aw_addr_r) == `BPS_ADDR_CTRL && w_strb_r[1]
                      && w_data_r[`BPS_CTRL_ALMCLR];
   assign clr_tpl   = wr_go && byte_addr(aw_addr_r) == `BPS_ADDR_CTRL && w_strb_r[1]
                      && w_data_r[`BPS_CTRL_TPLCLR];
   assign match     = ((time_r ^ alarm_r) & amask_r) == 32'h0000_0000 && amask_r != '0;

   // mode switch, sampled on the clock edge only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= BPS_MAIN;
      end else begin
         unique case (mode_r)
            BPS_MAIN: begin
               if (sif.below_bat_hys && sif.below_trip) begin
                  mode_r <= BPS_BACKUP;
               end
            end
            BPS_BACKUP: begin
               if (sif.above_bat_hys || sif.above_trip_hys) begin
                  mode_r <= BPS_MAIN;
               end
            end
            default: mode_r <= BPS_MAIN;
         endcase
      end
   end

   // switchover stamps; a capture wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stamp_b_r   <= '0;
         stamp_b_v_r <= 1'b0;
         stamp_m_r   <= '0;
      end else begin
         if (mode_r == BPS_MAIN && sif.below_bat_hys && sif.below_trip && !stamp_b_v_r) begin
            stamp_b_r   <= time_r;
            stamp_b_v_r <= 1'b1;
         end else if (clr_ts) begin
            stamp_b_r   <= '0;
            stamp_b_v_r <= 1'b0;
         end
         if (in_backup && (sif.above_bat_hys || sif.above_trip_hys)) begin
            stamp_m_r <= time_r;
         end
      end
   end

   // total power loss: strap sampled by clocks, held until cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tpl_r      <= 1'b0;
         tpl_seen_r <= 1'b0;
      end else begin
         tpl_seen_r <= 1'b1;
         if (!tpl_seen_r || sif.both_lost) begin
            tpl_r <= tpl_r | sif.both_lost | !tpl_seen_r;
         end else if (clr_tpl) begin
            tpl_r <= 1'b0;
         end
      end
   end

   // brownout is status only; it never touches the bus gate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brown_r <= 1'b0;
      end else begin
         brown_r <= sif.below_brown;
      end
   end

   // battery level sampled only during a measurement in main mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meas_cnt_r <= '0;
         lb85_r     <= 1'b0;
         lb75_r     <= 1'b0;
      end else if (in_backup) begin
         meas_cnt_r <= '0;
      end else if (ctrl_r[`BPS_CTRL_TSE] && meas_cnt_r != `BPS_TEMP_SETTLE) begin
         meas_cnt_r <= meas_cnt_r + 8'h01;
         if (meas_cnt_r == `BPS_TEMP_SETTLE - 8'h01) begin
            lb85_r <= sif.bat_below85 | sif.bat_below75;
            lb75_r <= sif.bat_below75;
         end
      end else if (!ctrl_r[`BPS_CTRL_TSE]) begin
         meas_cnt_r <= '0;
      end
   end

   // temperature conversion keeps going in backup only if enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         temp_run     <= 1'b0;
         bat_meas_run <= 1'b0;
      end else begin
         temp_run     <= ctrl_r[`BPS_CTRL_TSE] && (!in_backup || ctrl_r[`BPS_CTRL_BATTERY_MODE_TEMP_ENABLE]);
         bat_meas_run <= ctrl_r[`BPS_CTRL_TSE] && !in_backup && meas_cnt_r != `BPS_TEMP_SETTLE;
      end
   end

   // time keeping carries on in backup; alarm flag set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_r      <= '0;
         match_d_r   <= 1'b0;
         alarm_r_f   <= 1'b0;
         pulse_cnt_r <= '0;
      end else begin
         time_r    <= time_r + 32'h0000_0001;
         match_d_r <= match;
         if (ctrl_r[`BPS_CTRL_ALM_EN] && match && !match_d_r) begin
            alarm_r_f <= 1'b1;
            if (ctrl_r[`BPS_CTRL_REPEAT]) begin
               pulse_cnt_r <= 32'(PULSE_CYC);
            end
         end else begin
            if (clr_alarm) begin
               alarm_r_f <= 1'b0;
            end
            if (pulse_cnt_r != '0) begin
               pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
            end
         end
      end
   end

   // shared pin: frequency role or active-low interrupt, open drain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_or_freq_pin_out <= 1'b0;
         interrupt_or_freq_pin_oe  <= 1'b0;
      end else begin
         interrupt_or_freq_pin_out <= 1'b0;
         if (freq_mode) begin
            interrupt_or_freq_pin_oe <= !freq_taps[ctrl_r[`BPS_CTRL_FSEL_LSB +: `BPS_CTRL_FSEL_W]];
         end else if (ctrl_r[`BPS_CTRL_REPEAT]) begin
            interrupt_or_freq_pin_oe <= pulse_cnt_r != '0;
         end else begin
            interrupt_or_freq_pin_oe <= alarm_r_f && ctrl_r[`BPS_CTRL_ALM_EN];
         end
      end
   end

   // serial pins: synchronised, gated off in backup, data only pulled low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_s_r   <= 2'b11;
         sda_s_r   <= 2'b11;
         scl_gated <= 1'b1;
         sda_gated <= 1'b1;
         sda_out   <= 1'b0;
         sda_oe    <= 1'b0;
      end else begin
         scl_s_r   <= {scl_s_r[0], scl_in};
         sda_s_r   <= {sda_s_r[0], sda_in};
         scl_gated <= in_backup ? 1'b1 : scl_s_r[1];
         sda_gated <= in_backup ? 1'b1 : sda_s_r[1];
         sda_out   <= 1'b0;
         sda_oe    <= sda_drive_low && !in_backup;
      end
   end

   // axi4-lite write side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= '0;
         w_data_r      <= '0;
         w_strb_r      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `BPS_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (byte_addr(aw_addr_r) > `BPS_ADDR_BROWN) ? `BPS_RESP_SLVERR
                                                                    : `BPS_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
         end
      end
   end

   // writable registers; clear bits are self-clearing strobes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r      <= '0;
         alarm_r     <= '0;
         amask_r     <= '0;
         brown_sel_r <= 6'h01 << `BPS_BROWN_RST;
      end else if (wr_go) begin
         unique case (byte_addr(aw_addr_r))
            `BPS_ADDR_CTRL: begin
               if (w_strb_r[0]) ctrl_r[7:0] <= w_data_r[7:0];
            end
            `BPS_ADDR_ALARM: begin
               alarm_r <= w_data_r;
            end
            `BPS_ADDR_AMASK: begin
               amask_r <= w_data_r;
            end
            `BPS_ADDR_BROWN: begin
               if (w_data_r[2:0] < 3'(`BPS_BROWN_LEVELS)) begin
                  brown_sel_r <= 6'h01 << w_data_r[2:0];
               end
            end
            default: ;
         endcase
      end
   end

   // axi4-lite read side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `BPS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `BPS_RESP_OKAY;
            unique case (byte_addr(s_axi_araddr))
               `BPS_ADDR_CTRL:    s_axi_rdata <= {21'h0, ctrl_r};
               `BPS_ADDR_STATUS:  s_axi_rdata <= {23'h0, stamp_b_v_r, !in_backup, temp_run,
                                                  alarm_r_f, lb75_r, lb85_r, brown_r, tpl_r,
                                                  in_backup};
               `BPS_ADDR_STAMP_B: s_axi_rdata <= stamp_b_r;
               `BPS_ADDR_STAMP_M: s_axi_rdata <= stamp_m_r;
               `BPS_ADDR_TIME:    s_axi_rdata <= time_r;
               `BPS_ADDR_ALARM:   s_axi_rdata <= alarm_r;
               `BPS_ADDR_AMASK:   s_axi_rdata <= amask_r;
               `BPS_ADDR_BROWN:   s_axi_rdata <= {26'h0, brown_sel_r};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= `BPS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // bps_top

/* logic/bps_consts.svh */
// constants for the backup power supervisor
`ifndef BPS_CONSTS_SVH
`define BPS_CONSTS_SVH
`define BPS_ADDR_CTRL      8'h00
`define BPS_ADDR_STATUS    8'h04
`define BPS_ADDR_STAMP_B   8'h08
`define BPS_ADDR_STAMP_M   8'h0c
`define BPS_ADDR_TIME      8'h10
`define BPS_ADDR_ALARM     8'h14
`define BPS_ADDR_AMASK     8'h18
`define BPS_ADDR_BROWN     8'h1c
`define BPS_CTRL_FSEL_LSB  0
`define BPS_CTRL_FSEL_W    4
`define BPS_CTRL_ALM_EN    4
`define BPS_CTRL_REPEAT    5
`define BPS_CTRL_BATTERY_MODE_TEMP_ENABLE      6
`define BPS_CTRL_TSE       7
`define BPS_CTRL_STAMP_CLEAR_CONTROL     8
`define BPS_CTRL_ALMCLR    9
`define BPS_CTRL_TPLCLR    10
`define BPS_ST_BACKUP      0
`define BPS_ST_TPL         1
`define BPS_ST_BROWN       2
`define BPS_ST_LB85        3
`define BPS_ST_LB75        4
`define BPS_ST_ALARM       5
`define BPS_ST_TEMPRUN     6
`define BPS_ST_BUSON       7
`define BPS_ST_STAMPB_V    8
`define BPS_BROWN_LEVELS   6
`define BPS_BROWN_RST      3'h0
`define BPS_TEMP_SETTLE    8'h04
`define BPS_PULSE_MS       250
`define BPS_CLK_HZ         40000000
`define BPS_RESP_OKAY      2'h0
`define BPS_RESP_SLVERR    2'h2
`endif

/* logic/bps_pkg.sv */
// types shared by the backup power supervisor modules
package bps_pkg;
   typedef enum logic [1:0] {
      BPS_MAIN   = 2'b01,
      BPS_BACKUP = 2'b10
   } bps_mode_e;
   typedef logic [31:0] bps_word_t;
endpackage

/* logic/bps_sync_if.sv */
// synchronised comparator levels handed from the synchroniser to the supervisor
`timescale 1ns/1ps
interface bps_sync_if;
   logic       below_bat_hys;
   logic       below_trip;
   logic       above_bat_hys;
   logic       above_trip_hys;
   logic       below_brown;
   logic       bat_below85;
   logic       bat_below75;
   logic       both_lost;
   modport src (output below_bat_hys, below_trip, above_bat_hys, above_trip_hys,
                below_brown, bat_below85, bat_below75, both_lost);
   modport dst (input below_bat_hys, below_trip, above_bat_hys, above_trip_hys,
                below_brown, bat_below85, bat_below75, both_lost);
endinterface

/* logic/bps_sync.sv */
// two-flop synchroniser for the analog comparator levels
`timescale 1ns/1ps
module bps_sync #(
   parameter int W = 13
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] din,
   input  wire logic [5:0]   brown_sel,
   bps_sync_if.src           so
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic         brown_r;

   // first stage is read by the second stage only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
      end
   end

   // pick one of the six brownout comparators after synchronising
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brown_r <= 1'b0;
      end else begin
         brown_r <= |(s2_r[12:7] & brown_sel);
      end
   end

   assign so.below_bat_hys  = s2_r[0];
   assign so.below_trip     = s2_r[1];
   assign so.above_bat_hys  = s2_r[2];
   assign so.above_trip_hys = s2_r[3];
   assign so.bat_below85    = s2_r[4];
   assign so.bat_below75    = s2_r[5];
   assign so.both_lost      = s2_r[6];
   assign so.below_brown    = brown_r;
endmodule // bps_sync

/* verification/bps_host_model.sv */
// host side of the two-wire serial bus, with the pull-up on the data line
`timescale 1ns/1ps
module bps_host_model (
   input  wire logic aclk,
   input  wire logic run,
   input  wire logic sda_oe,
   output logic      scl_in,
   output logic      sda_in
);
   logic       host_low;
   logic [3:0] div;
   initial begin
      scl_in = 1'b1;
      host_low = 1'b0;
      div = 4'h0;
   end
   // clock stands high between frames, as a released line would
   always @(posedge aclk) begin
      div <= div + 4'h1;
      if (!run)
         scl_in <= 1'b1;
      else if (div == 4'hf)
         scl_in <= !scl_in;
      if (!run)
         host_low <= 1'b0;
      else if (div == 4'h7)
         host_low <= 1'($urandom_range(1));
   end
   assign sda_in = !(sda_oe || host_low);
endmodule // bps_host_model

/* verification/bps_top_checker.sv */
// concurrent checks on the supervisor's pins
`timescale 1ns/1ps
module bps_top_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [12:0] cmp_in,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_drive_low,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        scl_gated,
   input wire logic        sda_gated,
   input wire logic        interrupt_or_freq_pin_out,
   input wire logic        bat_meas_run
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_sda_open_drain: assert property (sda_out == 1'b0)
      else $error("serial data driven high");
   a_pin_open_drain: assert property (interrupt_or_freq_pin_out == 1'b0)
      else $error("shared pin driven high");
   // six samples cover two sync flops, the mode flop and the output flop
   a_backup_gates_bus: assert property (
      (cmp_in[3:0] == 4'h3)[*6] |-> scl_gated && sda_gated && !sda_oe && !bat_meas_run)
      else $error("bus or measurement active in backup");
   a_trip_return: assert property (
      (cmp_in[3] && !cmp_in[1] && !scl_in)[*6] |-> !scl_gated)
      else $error("serial clock gated above trip level");
   a_bat_return: assert property (
      (cmp_in[2] && !cmp_in[0] && !scl_in)[*6] |-> !scl_gated)
      else $error("serial clock gated above battery level");
   a_data_return: assert property (
      (cmp_in[2] && !cmp_in[0] && !sda_in)[*6] |-> !sda_gated)
      else $error("serial data gated in main mode");
   a_brown_keeps_bus: assert property (
      (cmp_in[2] && cmp_in[12:7] != 6'h0 && !scl_in)[*6] |-> !scl_gated)
      else $error("brownout gated the serial clock");
   a_oe_cause: assert property (
      $rose(sda_oe) |-> $past(sda_drive_low) || $past(sda_drive_low, 2)
         || $past(sda_drive_low, 3))
      else $error("serial data pulled low without request");
   a_oe_follows: assert property (
      (sda_drive_low && cmp_in[3:0] == 4'h4)[*6] |-> sda_oe)
      else $error("serial data not pulled low on request");
endmodule // bps_top_checker
bind bps_top bps_top_checker u_chk (.aclk(aclk), .aresetn(aresetn), .cmp_in(cmp_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_drive_low(sda_drive_low), .sda_out(sda_out),
   .sda_oe(sda_oe),
   .scl_gated(scl_gated), .sda_gated(sda_gated), .interrupt_or_freq_pin_out(interrupt_or_freq_pin_out),
   .bat_meas_run(bat_meas_run));

/* verification/backup_power_supervisor_test.sv */
// self-checking bench for the backup power supervisor
`timescale 1ns/1ps
`include "bps_consts.svh"
module backup_power_supervisor_test;
   import bps_pkg::*;
   localparam int PULSE = 20;
   logic        aclk, aresetn, awv, wv, arv, brdy, rrdy, run, drv_low, scl_in, sda_in;
   logic        awr, wrdy, bv, arr, rv, sda_out, sda_oe, scl_g, sda_g, fo_out, fo_oe;
   logic        t_run, b_run;
   logic [4:0]  awa, ara;
   logic [3:0]  ws;
   logic [1:0]  br, rr, resp;
   logic [12:0] cmp_in;
   logic [15:0] taps;
   bps_word_t   wd, rdat, v, t0, sb;
   int          failures, checked, n, k;
   bps_top #(.PULSE_CYC(PULSE)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr_lo(4'h0),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rrdy), .cmp_in(cmp_in), .scl_in(scl_in), .sda_in(sda_in),
      .sda_drive_low(drv_low), .freq_taps(taps), .sda_out(sda_out), .sda_oe(sda_oe),
      .scl_gated(scl_g), .sda_gated(sda_g), .interrupt_or_freq_pin_out(fo_out), .interrupt_or_freq_pin_oe(fo_oe),
      .temp_run(t_run), .bat_meas_run(b_run));
   bps_host_model host (.aclk(aclk), .run(run), .sda_oe(sda_oe), .scl_in(scl_in),
      .sda_in(sda_in));
   task automatic summarize;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input bps_word_t got, input bps_word_t exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      failures++;
      $display("MISMATCH at %0t: wait ran out", $time);
      summarize();
   endtask
   // ready and valid are sampled before this edge's updates land
   task automatic wr(input bps_word_t a, input bps_word_t d, input logic [3:0] s);
      int i;
      awa <= a[6:2];
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      i = 0;
      // one edge always passes: right after a handshake the old bvalid still reads high
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         i++;
      end while (i < 50 && (awv || wv || !bv));
      resp = br;
      if (!bv) hang();
   endtask
   task automatic rd(input bps_word_t a, output bps_word_t d);
      int i;
      ara <= a[6:2];
      arv <= 1'b1;
      i = 0;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
         i++;
      end while (i < 50 && !rv);
      d = rdat;
      resp = rr;
      if (!rv) hang();
   endtask
   task automatic wait_oe(input logic lvl, input int lim, output int c);
      for (c = 0; c < lim && fo_oe !== lvl; c++) @(posedge aclk);
      if (c == lim) hang();
   endtask
   task automatic toggles(input int len, output int c);
      logic p;
      c = 0;
      p = fo_oe;
      repeat (len) begin
         @(posedge aclk);
         if (fo_oe !== p) c++;
         p = fo_oe;
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      taps <= 16'($urandom);
      if (!aresetn) drv_low <= 1'b0;
      else if ($urandom_range(7) == 0) drv_low <= 1'($urandom_range(1));
   end
   initial begin
      repeat (100000) @(posedge aclk);
      hang();
   end
   initial begin
      void'($urandom(55433));
      {aresetn, awv, wv, arv} = 4'h0;
      {brdy, rrdy, run} = 3'h7;
      {awa, ara, ws, wd} = '0;
      cmp_in = 13'h004;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`BPS_ADDR_STATUS, v);
      check(v, 32'h82);
      wr(`BPS_ADDR_CTRL, 32'h400, 4'h3);
      rd(`BPS_ADDR_STATUS, v);
      check(v, 32'h80);
      rd(32'h20, v);
      check(v, 32'h0);
      check({30'h0, resp}, {30'h0, `BPS_RESP_SLVERR});
      wr(32'h24, 32'hffff, 4'hf);
      check({30'h0, resp}, {30'h0, `BPS_RESP_SLVERR});
      for (k = 0; k < 6; k++) begin
         wr(`BPS_ADDR_BROWN, k, 4'hf);
         rd(`BPS_ADDR_BROWN, v);
         check(v, 32'h1 << k);
         cmp_in <= 13'h004 | (13'h080 << k);
         repeat (8) @(posedge aclk);
         rd(`BPS_ADDR_STATUS, v);
         check(v & 32'h85, 32'h84);
      end
      wr(`BPS_ADDR_BROWN, 32'h6, 4'hf);
      rd(`BPS_ADDR_BROWN, v);
      check(v, 32'h20);
      for (k = 0; k < 2; k++) begin
         cmp_in <= 13'h030 | (k ? 13'h006 : 13'h009);
         wr(`BPS_ADDR_CTRL, 32'h00, 4'h1);
         wr(`BPS_ADDR_CTRL, 32'h80, 4'h1);
         repeat (8) @(posedge aclk);
         rd(`BPS_ADDR_STATUS, v);
         check(v & 32'h19, 32'h18);
      end
      for (k = 0; k < 2; k++) begin
         wr(`BPS_ADDR_CTRL, k ? 32'hc3 : 32'h83, 4'h1);
         rd(`BPS_ADDR_TIME, t0);
         cmp_in <= 13'h003;
         run <= 1'b0;
         repeat (8) @(posedge aclk);
         rd(`BPS_ADDR_STATUS, v);
         check(v & 32'h181, 32'h101);
         check({31'h0, scl_g}, 32'h1);
         check({31'h0, t_run}, k);
         toggles(30, n);
         check({31'h0, n > 0}, 32'h1);
         rd(`BPS_ADDR_STAMP_B, v);
         if (k == 0) begin
            sb = v;
            check({31'h0, v - t0 < 32'd20}, 32'h1);
         end
         else
            check(v, sb);
         repeat ($urandom_range(20)) @(posedge aclk);
         rd(`BPS_ADDR_TIME, t0);
         cmp_in <= k ? 13'h008 : 13'h004;
         run <= 1'b1;
         repeat (40) @(posedge aclk);
         rd(`BPS_ADDR_STAMP_M, v);
         check({31'h0, v - t0 < 32'd20}, 32'h1);
         rd(`BPS_ADDR_STATUS, v);
         check(v & 32'h81, 32'h80);
      end
      cmp_in <= 13'h004;
      wr(`BPS_ADDR_CTRL, 32'h100, 4'h2);
      rd(`BPS_ADDR_STAMP_B, v);
      check(v, 32'h0);
      for (k = 0; k < 16; k++) begin
         wr(`BPS_ADDR_CTRL, k, 4'h1);
         toggles(40, n);
         check({31'h0, n > 4}, {31'h0, k != 0});
      end
      t0 = $urandom_range(255);
      wr(`BPS_ADDR_ALARM, t0, 4'hf);
      wr(`BPS_ADDR_AMASK, 32'hff, 4'hf);
      wr(`BPS_ADDR_CTRL, 32'h10, 4'h1);
      wait_oe(1'b1, 600, n);
      rd(`BPS_ADDR_TIME, v);
      check({31'h0, v[7:0] - t0[7:0] < 8'd12}, 32'h1);
      rd(`BPS_ADDR_STATUS, v);
      check(v & 32'h20, 32'h20);
      repeat (30) @(posedge aclk);
      check({31'h0, fo_oe}, 32'h1);
      wr(`BPS_ADDR_CTRL, 32'h210, 4'h3);
      wait_oe(1'b0, 5, n);
      rd(`BPS_ADDR_STATUS, v);
      check(v & 32'h20, 32'h0);
      // repeat mode must release the pin after each pulse and fire again
      wr(`BPS_ADDR_CTRL, 32'h30, 4'h1);
      for (k = 0; k < 2; k++) begin
         wait_oe(1'b1, 600, n);
         wait_oe(1'b0, 100, n);
         check(n, PULSE);
      end
      summarize();
   end
endmodule // backup_power_supervisor_test
